/* hdl/feedback_pkg.sv */
package feedback_pkg;
   // ======================================================================
   // State byte offsets
   localparam logic [3:0] OFS_ENABLE = 4'h0;
   localparam logic [3:0] OFS_SPEED = 4'h1;
   localparam logic [3:0] OFS_PULLUP_DUR = 4'h2;
   localparam logic [3:0] OFS_PROG_DUR = 4'h3;
   localparam logic [3:0] OFS_SLEW = 4'h4;
   localparam logic [3:0] OFS_ONE_LOW = 4'h5;
   localparam logic [3:0] OFS_SAMPLE_REC = 4'h6;
   localparam logic [3:0] OFS_RSVD_A = 4'h7;
   localparam logic [3:0] OFS_STATUS = 4'h8;
   localparam logic [3:0] OFS_CMD_LOW = 4'h9;
   localparam logic [3:0] OFS_CMD_HIGH = 4'ha;
   localparam logic [3:0] OFS_CMD_LEVEL = 4'hb;
   localparam logic [3:0] OFS_WR_LEVEL = 4'hc;
   localparam logic [3:0] OFS_RD_LEVEL = 4'hd;
   localparam logic [3:0] OFS_RSVD_B = 4'he;
   localparam logic [3:0] OFS_RSVD_C = 4'hf;

   // ======================================================================
   // Bit positions
   localparam int EN_PULLUP_BIT = 0;
   localparam int EN_PROG_BIT = 1;
   localparam int EN_SPEED_BIT = 2;
   localparam int ST_PULLUP_ACT_BIT = 0;
   localparam int ST_PROG_ACT_BIT = 1;
   localparam int ST_SUPPLY_BIT = 2;
   localparam int ST_POWER_BIT = 3;
   localparam int ST_HALT_BIT = 4;
   localparam int ST_IDLE_BIT = 5;
   localparam int ST_OVERFLOW_BIT = 7;

   // ======================================================================
   // Sizes and fixed byte values
   localparam int STATE_BYTES = 16;
   localparam int SNAP_AW = 4;
   localparam int PKT_MAX = 32;
   localparam int RESULT_DEPTH_DEF = 16;
   localparam int CMD_DEPTH_DEF = 16;
   localparam int DATA_DEPTH_DEF = 128;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] RSVD_BYTE = 8'h00;
   localparam logic [7:0] IDLE_CMD_BYTE = 8'h00;
   localparam logic [7:0] NO_ERROR_BYTE = 8'h00;
   localparam logic [7:0] DETECT_BYTE = 8'ha5;

   // ======================================================================
   // Carriers
   typedef struct packed {
      logic strong_pullup_enable;
      logic prog_pulse_enable;
      logic speed_change_enable;
      logic [7:0] bus_speed_code;
      logic [7:0] pullup_duration_code;
      logic [7:0] prog_pulse_duration_code;
      logic [7:0] pulldown_slew_code;
      logic [7:0] one_bit_low_time_code;
      logic [7:0] sample_offset_recovery_code;
      logic strong_pullup_active;
      logic prog_pulse_active;
      logic prog_supply_present;
      logic external_power_mode;
      logic halted;
      logic idle;
      logic [7:0] active_command_low;
      logic [7:0] active_command_high;
      logic [7:0] command_queue_level;
      logic [7:0] write_queue_level;
      logic [7:0] read_queue_level;
   } bridge_state_t;

   typedef struct packed {
      logic done;
      logic notify_result_bit;
      logic suppress_result_bit;
      logic error;
      logic [7:0] error_code;
   } cmd_result_t;

   typedef enum logic [1:0] {
      ST_WAIT = 2'b00,
      ST_SEND = 2'b01
   } send_state_t;
endpackage : feedback_pkg

/* hdl/bridge_state_feedback_regs.sv */
module bridge_state_feedback_regs
   import feedback_pkg::*;
#(
   parameter int RESULT_DEPTH = RESULT_DEPTH_DEF,
   parameter int CMD_DEPTH = CMD_DEPTH_DEF,
   parameter int DATA_DEPTH = DATA_DEPTH_DEF
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Live device state
   input wire bridge_state_t bridge_state,
   // Command results and attach detection
   input wire cmd_result_t cmd_result,
   input wire logic attach_detect,
   // Control endpoint FIFO
   input wire logic setup_arrive,
   input wire logic ctrl_fifo_full,
   input wire logic device_reset_control_cmd,
   output logic setup_discard,
   output logic control_fifo_overflow,
   // Interrupt IN stream
   input wire logic poll_req,
   input wire logic tx_ready,
   output logic tx_valid,
   output logic [7:0] tx_data,
   output logic tx_last,
   output logic tx_short
);
   // ======================================================================
   // Parameter checks
   localparam int PW = $clog2(RESULT_DEPTH);
   localparam int CW = PW + 1;
   localparam int IW = $clog2(STATE_BYTES + RESULT_DEPTH + 1);

   initial begin
      if (RESULT_DEPTH < 2 || RESULT_DEPTH > PKT_MAX - STATE_BYTES || (1 << PW) != RESULT_DEPTH) begin
         $error("RESULT_DEPTH must be a power of two from 2 to 16");
      end
      if (CMD_DEPTH < 1 || CMD_DEPTH > 255 || DATA_DEPTH < 1 || DATA_DEPTH > 255) begin
         $error("FIFO depths must fit in one byte");
      end
   end

   // ======================================================================
   // Declarations
   send_state_t state_reg;
   logic [STATE_BYTES-1:0][7:0] snap_reg;
   logic [STATE_BYTES-1:0][7:0] snap_next;
   logic [RESULT_DEPTH-1:0][7:0] res_buf_reg;
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] rd_ptr_reg;
   logic [CW-1:0] res_cnt_reg;
   logic [IW-1:0] idx_reg;
   logic [IW-1:0] pkt_len_reg;
   logic detect_pend_reg;
   logic overflow_reg;
   logic discard_reg;
   logic tx_valid_reg;
   logic [7:0] tx_data_reg;
   logic tx_last_reg;
   logic tx_short_reg;
   logic poll_take;
   logic res_push_cmd;
   logic push_req;
   logic [7:0] push_byte;
   logic pop;
   logic push_en;

   // ======================================================================
   // Control FIFO overflow
   always_ff @(posedge core_clk) begin
      if (srst) begin
         overflow_reg <= 1'b0;
      end else if (setup_arrive && ctrl_fifo_full) begin
         overflow_reg <= 1'b1;
      end else if (device_reset_control_cmd) begin
         overflow_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         discard_reg <= 1'b0;
      end else begin
         discard_reg <= setup_arrive && ctrl_fifo_full;
      end
   end

   // ======================================================================
   // State snapshot
   always_comb begin
      snap_next = '0;
      snap_next[OFS_ENABLE][EN_PULLUP_BIT] = bridge_state.strong_pullup_enable;
      snap_next[OFS_ENABLE][EN_PROG_BIT] = bridge_state.prog_pulse_enable;
      snap_next[OFS_ENABLE][EN_SPEED_BIT] = bridge_state.speed_change_enable;
      snap_next[OFS_SPEED] = bridge_state.bus_speed_code;
      snap_next[OFS_PULLUP_DUR] = bridge_state.pullup_duration_code;
      snap_next[OFS_PROG_DUR] = bridge_state.prog_pulse_duration_code;
      snap_next[OFS_SLEW] = bridge_state.pulldown_slew_code;
      snap_next[OFS_ONE_LOW] = bridge_state.one_bit_low_time_code;
      snap_next[OFS_SAMPLE_REC] = bridge_state.sample_offset_recovery_code;
      snap_next[OFS_RSVD_A] = RSVD_BYTE;
      snap_next[OFS_STATUS][ST_PULLUP_ACT_BIT] = bridge_state.strong_pullup_active;
      snap_next[OFS_STATUS][ST_PROG_ACT_BIT] = bridge_state.prog_pulse_active;
      snap_next[OFS_STATUS][ST_SUPPLY_BIT] = bridge_state.prog_supply_present;
      snap_next[OFS_STATUS][ST_POWER_BIT] = bridge_state.external_power_mode;
      snap_next[OFS_STATUS][ST_HALT_BIT] = bridge_state.halted;
      snap_next[OFS_STATUS][ST_IDLE_BIT] = bridge_state.idle;
      snap_next[OFS_STATUS][ST_OVERFLOW_BIT] = overflow_reg;
      snap_next[OFS_CMD_LOW] = bridge_state.idle ? IDLE_CMD_BYTE : bridge_state.active_command_low;
      snap_next[OFS_CMD_HIGH] = bridge_state.idle ? IDLE_CMD_BYTE : bridge_state.active_command_high;
      snap_next[OFS_CMD_LEVEL] = bridge_state.command_queue_level;
      snap_next[OFS_WR_LEVEL] = bridge_state.write_queue_level;
      snap_next[OFS_RD_LEVEL] = bridge_state.read_queue_level;
      snap_next[OFS_RSVD_B] = RSVD_BYTE;
      snap_next[OFS_RSVD_C] = RSVD_BYTE;
   end

   assign poll_take = (state_reg == ST_WAIT) && poll_req;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         snap_reg <= '0;
      end else if (poll_take) begin
         snap_reg <= snap_next;
      end
   end

   // ======================================================================
   // Result buffer
   assign res_push_cmd = cmd_result.done && !cmd_result.suppress_result_bit
                         && (cmd_result.error || cmd_result.notify_result_bit);
   assign push_req = res_push_cmd || detect_pend_reg || attach_detect;
   assign push_byte = res_push_cmd ? (cmd_result.error ? cmd_result.error_code : NO_ERROR_BYTE) : DETECT_BYTE;
   assign pop = (state_reg == ST_SEND) && tx_ready && (idx_reg != pkt_len_reg)
                && (idx_reg >= IW'(STATE_BYTES));
   assign push_en = push_req && ((res_cnt_reg < CW'(RESULT_DEPTH)) || pop);

   always_ff @(posedge core_clk) begin
      if (srst) begin
         detect_pend_reg <= 1'b0;
      end else if (attach_detect && res_push_cmd) begin
         detect_pend_reg <= 1'b1;
      end else if (push_en && !res_push_cmd) begin
         detect_pend_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         res_buf_reg <= '0;
         wr_ptr_reg <= '0;
      end else if (push_en) begin
         res_buf_reg[wr_ptr_reg] <= push_byte;
         wr_ptr_reg <= wr_ptr_reg + PW'(1);
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         rd_ptr_reg <= '0;
      end else if (pop) begin
         rd_ptr_reg <= rd_ptr_reg + PW'(1);
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         res_cnt_reg <= '0;
      end else if (push_en && !pop) begin
         res_cnt_reg <= res_cnt_reg + CW'(1);
      end else if (pop && !push_en) begin
         res_cnt_reg <= res_cnt_reg - CW'(1);
      end
   end

   // ======================================================================
   // Interrupt IN packet sender
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_reg <= ST_WAIT;
         idx_reg <= '0;
         pkt_len_reg <= '0;
         tx_valid_reg <= 1'b0;
         tx_data_reg <= RESET_BYTE;
         tx_last_reg <= 1'b0;
         tx_short_reg <= 1'b0;
      end else begin
         case (state_reg)
            ST_WAIT: begin
               if (poll_req) begin
                  state_reg <= ST_SEND;
                  pkt_len_reg <= IW'(STATE_BYTES) + IW'(res_cnt_reg);
                  tx_short_reg <= (IW'(STATE_BYTES) + IW'(res_cnt_reg)) < IW'(PKT_MAX);
                  tx_valid_reg <= 1'b1;
                  tx_data_reg <= snap_next[OFS_ENABLE];
                  tx_last_reg <= 1'b0;
                  idx_reg <= IW'(1);
               end
            end
            ST_SEND: begin
               if (tx_ready) begin
                  if (idx_reg == pkt_len_reg) begin
                     state_reg <= ST_WAIT;
                     tx_valid_reg <= 1'b0;
                     tx_last_reg <= 1'b0;
                     tx_short_reg <= 1'b0;
                  end else begin
                     if (idx_reg < IW'(STATE_BYTES)) begin
                        tx_data_reg <= snap_reg[idx_reg[SNAP_AW-1:0]];
                     end else begin
                        tx_data_reg <= res_buf_reg[rd_ptr_reg];
                     end
                     tx_last_reg <= (idx_reg == pkt_len_reg - IW'(1));
                     idx_reg <= idx_reg + IW'(1);
                  end
               end
            end
            default: begin
               state_reg <= ST_WAIT;
               tx_valid_reg <= 1'b0;
            end
         endcase
      end
   end

   assign setup_discard = discard_reg;
   assign control_fifo_overflow = overflow_reg;
   assign tx_valid = tx_valid_reg;
   assign tx_data = tx_data_reg;
   assign tx_last = tx_last_reg;
   assign tx_short = tx_short_reg;

   // ======================================================================
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   chk_enable_pullup: assert property (poll_take |=>
      snap_reg[OFS_ENABLE][EN_PULLUP_BIT] == $past(bridge_state.strong_pullup_enable))
      else $error("pullup enable bit wrong");
   chk_enable_prog: assert property (poll_take |=>
      snap_reg[OFS_ENABLE][EN_PROG_BIT] == $past(bridge_state.prog_pulse_enable))
      else $error("prog enable bit wrong");
   chk_enable_speed: assert property (poll_take |=>
      snap_reg[OFS_ENABLE][EN_SPEED_BIT] == $past(bridge_state.speed_change_enable))
      else $error("speed change bit wrong");
   chk_speed_code: assert property (poll_take |=>
      snap_reg[OFS_SPEED] == $past(bridge_state.bus_speed_code))
      else $error("speed code wrong");
   chk_duration_codes: assert property (poll_take |=>
      snap_reg[OFS_PULLUP_DUR] == $past(bridge_state.pullup_duration_code)
      && snap_reg[OFS_PROG_DUR] == $past(bridge_state.prog_pulse_duration_code))
      else $error("duration codes wrong");
   chk_slew_code: assert property (poll_take |=>
      snap_reg[OFS_SLEW] == $past(bridge_state.pulldown_slew_code))
      else $error("slew code wrong");
   chk_low_time: assert property (poll_take |=>
      snap_reg[OFS_ONE_LOW] == $past(bridge_state.one_bit_low_time_code))
      else $error("low time code wrong");
   chk_sample_code: assert property (poll_take |=>
      snap_reg[OFS_SAMPLE_REC] == $past(bridge_state.sample_offset_recovery_code))
      else $error("sample code wrong");
   chk_status_active: assert property (poll_take |=>
      snap_reg[OFS_STATUS][ST_PULLUP_ACT_BIT] == $past(bridge_state.strong_pullup_active))
      else $error("pullup active bit wrong");
   chk_status_prog: assert property (poll_take |=>
      snap_reg[OFS_STATUS][ST_PROG_ACT_BIT] == $past(bridge_state.prog_pulse_active))
      else $error("prog active bit wrong");
   chk_status_supply: assert property (poll_take |=>
      snap_reg[OFS_STATUS][ST_SUPPLY_BIT] == $past(bridge_state.prog_supply_present))
      else $error("supply bit wrong");
   chk_status_power: assert property (poll_take |=>
      snap_reg[OFS_STATUS][ST_POWER_BIT] == $past(bridge_state.external_power_mode))
      else $error("power mode bit wrong");
   chk_status_halt: assert property (poll_take |=>
      snap_reg[OFS_STATUS][ST_HALT_BIT] == $past(bridge_state.halted))
      else $error("halt bit wrong");
   chk_status_idle: assert property (poll_take |=>
      snap_reg[OFS_STATUS][ST_IDLE_BIT] == $past(bridge_state.idle))
      else $error("idle bit wrong");
   chk_status_overflow: assert property (poll_take |=>
      snap_reg[OFS_STATUS][ST_OVERFLOW_BIT] == $past(overflow_reg) && !snap_reg[OFS_STATUS][6])
      else $error("overflow bit wrong");
   chk_overflow_set: assert property (setup_arrive && ctrl_fifo_full |=>
      overflow_reg && setup_discard ##1 !setup_discard || $past(setup_arrive && ctrl_fifo_full))
      else $error("overflow not set on discard");
   chk_overflow_clear: assert property (device_reset_control_cmd && !(setup_arrive && ctrl_fifo_full) |=>
      !overflow_reg)
      else $error("overflow not cleared");
   chk_idle_command: assert property (poll_take && bridge_state.idle |=>
      snap_reg[OFS_CMD_LOW] == IDLE_CMD_BYTE && snap_reg[OFS_CMD_HIGH] == IDLE_CMD_BYTE)
      else $error("idle command not zero");
   chk_cmd_level: assert property (poll_take |=>
      snap_reg[OFS_CMD_LEVEL] == $past(bridge_state.command_queue_level))
      else $error("command level wrong");
   chk_write_level: assert property (poll_take |=>
      snap_reg[OFS_WR_LEVEL] == $past(bridge_state.write_queue_level))
      else $error("write level wrong");
   chk_read_level: assert property (poll_take |=>
      snap_reg[OFS_RD_LEVEL] == $past(bridge_state.read_queue_level))
      else $error("read level wrong");
   chk_result_count: assert property (push_en && !pop |=>
      res_cnt_reg == $past(res_cnt_reg) + 1)
      else $error("result count not advanced");
   chk_packet_length: assert property (poll_take |=>
      pkt_len_reg == STATE_BYTES + $past(res_cnt_reg) && tx_valid && tx_data == snap_reg[OFS_ENABLE])
      else $error("packet length wrong");
   chk_short_flag: assert property (tx_valid && tx_last |->
      tx_short == (pkt_len_reg < PKT_MAX) && idx_reg == pkt_len_reg)
      else $error("short flag wrong");
   chk_reserved_zero: assert property (snap_reg[OFS_RSVD_A] == RSVD_BYTE
      && snap_reg[OFS_RSVD_B] == RSVD_BYTE && snap_reg[OFS_RSVD_C] == RSVD_BYTE
      && snap_reg[OFS_ENABLE][7:3] == '0)
      else $error("reserved bytes not zero");

   chk_command_live: assert property (poll_take && !bridge_state.idle |=>
      snap_reg[OFS_CMD_LOW] == $past(bridge_state.active_command_low)
      && snap_reg[OFS_CMD_HIGH] == $past(bridge_state.active_command_high))
      else $error("active command bytes wrong");
   chk_result_bound: assert property (res_cnt_reg <= CW'(RESULT_DEPTH))
      else $error("result count above depth");
   chk_state_order: assert property (state_reg == ST_SEND && idx_reg <= IW'(STATE_BYTES) |->
      tx_data == snap_reg[SNAP_AW'(idx_reg - IW'(1))])
      else $error("state byte out of order");
   chk_result_order: assert property (pop |=>
      tx_data == $past(res_buf_reg[rd_ptr_reg]))
      else $error("result byte out of order");
   chk_byte_hold: assert property (state_reg == ST_SEND && !tx_ready |=>
      tx_valid && $stable(tx_data) && $stable(tx_last))
      else $error("byte not held while stalled");
   chk_idle_stream: assert property (state_reg == ST_WAIT |->
      !tx_valid && !tx_last)
      else $error("stream active while waiting");
   chk_packet_end: assert property (state_reg == ST_SEND && tx_ready && idx_reg == pkt_len_reg |=>
      !tx_valid && state_reg == ST_WAIT)
      else $error("packet not ended after last byte");
   chk_discard_pulse: assert property (setup_discard |->
      $past(setup_arrive && ctrl_fifo_full))
      else $error("discard without full arrival");
   chk_short_steady: assert property (state_reg == ST_SEND && tx_valid |->
      tx_short == (pkt_len_reg < IW'(PKT_MAX)))
      else $error("short flag unsteady");

   cov_state_only: cover property (poll_take && res_cnt_reg == '0);
   cov_full_packet: cover property (tx_valid && tx_last && !tx_short);
   cov_overflow: cover property (setup_arrive && ctrl_fifo_full);
   cov_detect_result: cover property (attach_detect && res_push_cmd);
   cov_mid_result: cover property (state_reg == ST_SEND && push_en);
endmodule : bridge_state_feedback_regs

/* test/usb_host_poller.sv */
module usb_host_poller
   import feedback_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Bench control
   input wire logic start,
   input wire logic stall,
   // Stream from the device
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_last,
   input wire logic tx_short,
   output logic poll_req,
   output logic tx_ready,
   // Bytes handed to the bench
   output logic got,
   output logic [7:0] got_data,
   output logic got_last,
   output logic got_short
);
   timeunit 1ns;
   timeprecision 1ps;

   logic in_pkt_reg;

   // ======================================================================
   // Poll and accept
   always_ff @(posedge core_clk) begin
      if (srst) begin
         poll_req <= 1'b0;
         tx_ready <= 1'b0;
         in_pkt_reg <= 1'b0;
         got <= 1'b0;
      end else begin
         got <= 1'b0;
         poll_req <= 1'b0;
         tx_ready <= in_pkt_reg && !stall;
         if (start && !in_pkt_reg && !tx_valid) begin
            poll_req <= 1'b1;
            in_pkt_reg <= 1'b1;
         end
         if (tx_valid && tx_ready) begin
            got <= 1'b1;
            got_data <= tx_data;
            got_last <= tx_last;
            got_short <= tx_short;
            if (tx_last) begin
               in_pkt_reg <= 1'b0;
            end
         end
      end
   end
endmodule : usb_host_poller

/* test/testbench.sv */
module testbench;
   import feedback_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [7:0] data;
      logic last;
      logic short_pkt;
   } exp_t;

   // ======================================================================
   // Signals
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   bridge_state_t bridge_state = '0;
   cmd_result_t cmd_result = '0;
   logic attach_detect = 1'b0;
   logic setup_arrive = 1'b0;
   logic ctrl_fifo_full = 1'b0;
   logic device_reset_control_cmd = 1'b0;
   logic start = 1'b0;
   logic stall = 1'b0;
   logic slow = 1'b0;
   logic ovf = 1'b0;
   logic setup_discard, control_fifo_overflow, poll_req, tx_ready, tx_valid, tx_last, tx_short;
   logic got, got_last, got_short;
   logic [7:0] tx_data, got_data;
   int n_errors = 0;
   int n_compared = 0;
   int cycles = 0;
   exp_t exp_q[$];
   exp_t e;
   logic [7:0] res_q[$];

   always #5ns core_clk = ~core_clk;

   bridge_state_feedback_regs i_dut (.core_clk(core_clk), .srst(srst), .bridge_state(bridge_state),
      .cmd_result(cmd_result), .attach_detect(attach_detect), .setup_arrive(setup_arrive),
      .ctrl_fifo_full(ctrl_fifo_full), .device_reset_control_cmd(device_reset_control_cmd),
      .setup_discard(setup_discard), .control_fifo_overflow(control_fifo_overflow), .poll_req(poll_req),
      .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_short(tx_short));

   usb_host_poller i_host (.core_clk(core_clk), .srst(srst), .start(start), .stall(stall), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_last(tx_last), .tx_short(tx_short), .poll_req(poll_req), .tx_ready(tx_ready),
      .got(got), .got_data(got_data), .got_last(got_last), .got_short(got_short));

   // ======================================================================
   // Compare and finish
   task automatic check_byte(input string what, input logic [7:0] expv, input logic [7:0] seen);
      n_compared++;
      if (seen !== expv) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, expv, seen);
      end
   endtask : check_byte

   task automatic check_flag(input string what, input logic expv, input logic seen);
      n_compared++;
      if (seen !== expv) begin
         n_errors++;
         $display("MISMATCH %s expected %b seen %b", what, expv, seen);
      end
   endtask : check_flag

   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : test_done

   // ======================================================================
   // Expected values
   function automatic logic [7:0] state_byte(input int i);
      bridge_state_t s;
      s = bridge_state;
      case (i)
         0: state_byte = {5'h00, s.speed_change_enable, s.prog_pulse_enable, s.strong_pullup_enable};
         1: state_byte = s.bus_speed_code;
         2: state_byte = s.pullup_duration_code;
         3: state_byte = s.prog_pulse_duration_code;
         4: state_byte = s.pulldown_slew_code;
         5: state_byte = s.one_bit_low_time_code;
         6: state_byte = s.sample_offset_recovery_code;
         8: state_byte = {ovf, 1'b0, s.idle, s.halted, s.external_power_mode, s.prog_supply_present,
               s.prog_pulse_active, s.strong_pullup_active};
         9: state_byte = s.idle ? 8'h00 : s.active_command_low;
         10: state_byte = s.idle ? 8'h00 : s.active_command_high;
         11: state_byte = s.command_queue_level;
         12: state_byte = s.write_queue_level;
         13: state_byte = s.read_queue_level;
         default: state_byte = 8'h00;
      endcase
   endfunction : state_byte

   function automatic bridge_state_t rnd_state();
      logic [127:0] r;
      r = {$urandom, $urandom, $urandom, $urandom};
      return r[$bits(bridge_state_t)-1:0];
   endfunction : rnd_state

   // ======================================================================
   // Drivers
   task automatic result(input logic nt, input logic sp, input logic er, input logic [7:0] code, input logic att);
      @(posedge core_clk);
      cmd_result <= '{1'b1, nt, sp, er, code};
      attach_detect <= att;
      if (!sp && (er || nt) && res_q.size() < RESULT_DEPTH_DEF) begin
         res_q.push_back(er ? code : 8'h00);
      end
      if (att && res_q.size() < RESULT_DEPTH_DEF) begin
         res_q.push_back(8'ha5);
      end
      @(posedge core_clk);
      cmd_result <= '0;
      attach_detect <= 1'b0;
   endtask : result

   task automatic poll(input logic mid);
      int n;
      @(posedge core_clk);
      n = STATE_BYTES + res_q.size();
      for (int i = 0; i < n; i++) begin
         exp_q.push_back('{i < STATE_BYTES ? state_byte(i) : res_q[i-STATE_BYTES], i == n - 1, n < PKT_MAX});
      end
      res_q.delete();
      start <= 1'b1;
      @(posedge core_clk);
      start <= 1'b0;
      @(posedge core_clk);
      bridge_state <= rnd_state();
      if (mid) begin
         result(1'b1, 1'b0, 1'b0, 8'h00, 1'b0);
      end
      for (int k = 0; k < 400 && (exp_q.size() > 0 || tx_valid !== 1'b0); k++) begin
         @(posedge core_clk);
      end
   endtask : poll

   task automatic setup_pulse(input logic full, input logic rst);
      @(posedge core_clk);
      setup_arrive <= 1'b1;
      ctrl_fifo_full <= full;
      device_reset_control_cmd <= rst;
      @(posedge core_clk);
      setup_arrive <= 1'b0;
      device_reset_control_cmd <= 1'b0;
      ovf = full ? 1'b1 : (rst ? 1'b0 : ovf);
      #1;
      check_flag("setup_discard", full, setup_discard);
      check_flag("control_fifo_overflow", ovf, control_fifo_overflow);
   endtask : setup_pulse

   // ======================================================================
   // Monitor, stall and timeout
   always @(posedge core_clk) begin
      stall <= slow ? 1'($urandom_range(1)) : 1'b0;
      if (got === 1'b1) begin
         if (exp_q.size() == 0) begin
            check_flag("extra byte", 1'b0, 1'b1);
         end else begin
            e = exp_q.pop_front();
            check_byte("tx_data", e.data, got_data);
            check_flag("tx_last", e.last, got_last);
            check_flag("tx_short", e.short_pkt, got_short);
         end
      end
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         $display("MISMATCH timeout expected finish seen hang");
         test_done();
      end
   end

   // ======================================================================
   // Main sequence
   initial begin
      int seed;
      seed = $urandom(32'h878f);
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         poll(1'b0);
      end
      $display("test state bytes done");
      slow <= 1'b1;
      result(1'b0, 1'b0, 1'b1, 8'($urandom), 1'b0);
      result(1'b1, 1'b0, 1'b0, 8'h00, 1'b1);
      result(1'b0, 1'b0, 1'b0, 8'h00, 1'b0);
      result(1'b1, 1'b1, 1'b1, 8'h42, 1'b1);
      poll(1'b1);
      poll(1'b0);
      $display("test result bytes done");
      for (int i = 0; i < 18; i++) begin
         result(1'b1, 1'b0, 1'b1, 8'($urandom), 1'b0);
      end
      poll(1'b0);
      $display("test full packet done");
      setup_pulse(1'b1, 1'b0);
      setup_pulse(1'b0, 1'b0);
      poll(1'b0);
      setup_pulse(1'b1, 1'b1);
      setup_pulse(1'b0, 1'b1);
      poll(1'b0);
      $display("test overflow done");
      check_flag("all bytes seen", 1'b1, exp_q.size() == 0);
      test_done();
   end
endmodule : testbench
